// File: ebls_pkg.sv
// ebls_pkg: shared constants and carrier types for the external bus lane and strobe steering block
// assumes: single 200 MHz clock domain, no software-visible registers
package ebls_pkg;

  // ==========================================================================
  // sizes and encodings
  // ==========================================================================
  localparam int unsigned DATA_W = 16; // external data bus width
  localparam int unsigned ADDR_W = 24; // external address width
  localparam logic [1:0] SIZE_BYTE = 2'h0; // access size: byte
  localparam logic [1:0] SIZE_WORD = 2'h1; // access size: word
  localparam logic [1:0] SIZE_LONG = 2'h2; // access size: longword
  localparam logic [1:0] WAIT_MAX = 2'h3; // program wait upper bound
  localparam logic [1:0] RST_WAITS = 2'h3; // wait count after reset

  // ==========================================================================
  // timing counts (in bus states, one clock each)
  // ==========================================================================
  localparam logic [2:0] STATES_2 = 3'h2; // base length of a 2-state space
  localparam logic [2:0] STATES_3 = 3'h3; // base length of a 3-state space

  // ==========================================================================
  // carriers
  // ==========================================================================
  // request from the internal bus master
  typedef struct packed {
    logic [ADDR_W-1:0] addr; // byte address
    logic [1:0] size; // byte, word or longword
    logic write; // 1 write, 0 read
    logic [31:0] wdata; // write data, msb first on the bus
  } ebls_req_s;

  // per-space configuration
  typedef struct packed {
    logic wide; // 1 for a 16-bit space
    logic three_state; // 1 for a 3-state space
    logic [1:0] waits; // program wait states
    logic mux_mode_select; // address-data multiplexed mode
    logic byte_enable_mode; // glueless byte-enable scheme
  } ebls_cfg_s;

  // one bus cycle worth of lane steering
  typedef struct packed {
    logic upper; // upper half carries data
    logic lower; // lower half carries data
  } ebls_lane_s;

  // sequencer states, gray along idle-t1-t2-tw-t3
  typedef enum logic [2:0] {
    EBLS_IDLE = 3'h0,
    EBLS_T1 = 3'h1,
    EBLS_T2 = 3'h3,
    EBLS_TW = 3'h2,
    EBLS_T3 = 3'h6
  } ebls_state_e;

endpackage : ebls_pkg

// File: ebls_lane_sel.sv
// ebls_lane_sel: registered lane choice for one bus cycle
// assumes: inputs steady for the cycle in which load_i is high
`timescale 1ns/100ps
module ebls_lane_sel (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic load_i, // capture a new choice
  input wire logic wide_i, // 16-bit space
  input wire logic mux_i, // multiplexed mode
  input wire logic a0_i, // byte address parity
  input wire logic word_i, // word-wide bus cycle
  output ebls_pkg::ebls_lane_s lane_o // chosen halves
);

  // ==========================================================================
  // lane decode
  // ==========================================================================
  ebls_pkg::ebls_lane_s lane_reg;
  ebls_pkg::ebls_lane_s lane_next;

  // combinational choice of halves
  always_comb begin
    lane_next = lane_reg;
    if (load_i) begin
      if (!wide_i) begin
        lane_next.upper = !mux_i;
        lane_next.lower = mux_i;
      end else if (word_i) begin
        lane_next.upper = 1'b1;
        lane_next.lower = 1'b1;
      end else begin
        lane_next.upper = !a0_i; // even: upper
        lane_next.lower = a0_i; // odd: lower
      end
    end
  end

  // register the choice
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lane_reg <= '0;
    end else begin
      lane_reg <= lane_next;
    end
  end

  assign lane_o = lane_reg;

endmodule : ebls_lane_sel

// File: ebls_wait_cnt.sv
// ebls_wait_cnt: program wait counter for 3-state spaces
// assumes: load_i pulses at the start of a wait stretch
`timescale 1ns/100ps
module ebls_wait_cnt (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic load_i, // start counting
  input wire logic [1:0] waits_i, // waits to insert
  input wire logic dec_i, // one wait consumed
  output logic zero_o // no waits left
);

  // ==========================================================================
  // counter
  // ==========================================================================
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;

  // next count
  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = waits_i;
    end else if (dec_i && cnt_reg != 2'h0) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  // register the count
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign zero_o = (cnt_reg == 2'h0);

endmodule : ebls_wait_cnt

// File: ebls_top.sv
// ebls_top: external bus lane and strobe steering with bus-cycle sequencer
// assumes: request held until ack; external pins sampled synchronously
//
// Behaviour
// - normal scheme: read strobe qualifies both halves
// - normal writes: upper/lower strobes per half; 8-bit uses upper
// - byte-enable scheme: read/write strobes qualify both
// - 16-bit byte enables: even upper, odd lower, word both
// - normal 8-bit space uses upper half
// - multiplexed 8-bit space uses lower half
// - normal 16-bit byte: even upper, odd lower
// - multiplexed 16-bit byte: even upper, odd lower
// - byte read: unused half stays input, ignored
// - 16-bit byte write: unused half undefined output
// - 8-bit space: idle half stays port pins
// - 2-state space: two states, no waits
// - 3-state space: waits may be inserted
// - 8-bit space: word two, longword four cycles
// - 16-bit space: longword two word cycles
`timescale 1ns/100ps
module ebls_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i, // request pending
  input ebls_pkg::ebls_req_s req_i, // request contents
  input ebls_pkg::ebls_cfg_s cfg_i, // space configuration
  input wire logic [15:0] data_in_i, // external data pins in
  output logic req_ack_o, // one-cycle: transfer done
  output logic [31:0] rdata_o, // assembled read data
  output logic [15:0] data_out_o, // external data pins out
  output logic data_oe_upper_o, // drive upper half
  output logic data_oe_lower_o, // drive lower half
  output logic bus_upper_o, // upper half owned by bus
  output logic bus_lower_o, // lower half owned by bus
  output logic [23:0] addr_o, // external address
  output logic read_strobe_n_o, // read strobe
  output logic write_strobe_n_o, // single write strobe
  output logic upper_write_strobe_n_o, // upper write strobe
  output logic lower_write_strobe_n_o, // lower write strobe
  output logic upper_byte_enable_n_o, // upper byte enable
  output logic lower_byte_enable_n_o // lower byte enable
);

  // ==========================================================================
  // sequencer state
  // ==========================================================================
  ebls_pkg::ebls_state_e st_reg, st_next; // bus state
  logic [1:0] cyc_reg, cyc_next; // bus cycle index inside a transfer
  logic [1:0] last_reg, last_next; // index of the final bus cycle
  logic [31:0] rd_reg, rd_next; // read assembly
  logic ack_reg, ack_next; // completion pulse
  logic [23:0] addr_reg, addr_next; // address of current bus cycle
  logic [15:0] dout_reg, dout_next; // output data
  logic rstb_reg, rstb_next; // read strobe, active low
  logic wstb_reg, wstb_next; // single write strobe
  logic uwr_reg, uwr_next; // upper write strobe
  logic lwr_reg, lwr_next; // lower write strobe
  logic ube_reg, ube_next; // upper byte enable
  logic lbe_reg, lbe_next; // lower byte enable
  logic oeu_reg, oeu_next; // drive upper half
  logic oel_reg, oel_next; // drive lower half
  logic busu_reg, busu_next; // upper half owned
  logic busl_reg, busl_next; // lower half owned

  logic cyc_word; // bus cycle moves a word
  logic lane_load; // capture lanes in idle as a request is taken
  logic wait_load; // start wait count
  logic wait_zero; // no waits left
  ebls_pkg::ebls_lane_s lane; // registered lanes
  logic [7:0] wbyte; // byte for a byte cycle
  logic [15:0] wword; // word for a word cycle

  // word cycles only on a wide space with non-byte size
  assign cyc_word = cfg_i.wide && (req_i.size != ebls_pkg::SIZE_BYTE);
  // no take in the ack cycle, so a master still holding its request is not served twice
  assign lane_load = (st_reg == ebls_pkg::EBLS_IDLE) && req_valid_i && !ack_reg;
  // count loads at t1 and runs down from t2, so exactly the programmed waits follow
  assign wait_load = (st_reg == ebls_pkg::EBLS_T1) && cfg_i.three_state;

  // ==========================================================================
  // helpers
  // ==========================================================================
  ebls_lane_sel ebls_lane_sel_inst (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(lane_load),
    .wide_i(cfg_i.wide),
    .mux_i(cfg_i.mux_mode_select),
    .a0_i(addr_next[0]),
    .word_i(cyc_word),
    .lane_o(lane)
  );

  ebls_wait_cnt ebls_wait_cnt_inst (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(wait_load),
    .waits_i(cfg_i.waits),
    .dec_i((st_reg == ebls_pkg::EBLS_T2) || (st_reg == ebls_pkg::EBLS_TW)),
    .zero_o(wait_zero)
  );

  // write data slices, high order first
  always_comb begin
    wbyte = req_i.wdata[8*(3-cyc_reg) +: 8];
    wword = req_i.wdata[16*(1-cyc_reg[0]) +: 16];
    if (req_i.size == ebls_pkg::SIZE_WORD) begin
      wbyte = req_i.wdata[8*(1-cyc_reg[0]) +: 8];
      wword = req_i.wdata[15:0];
    end else if (req_i.size == ebls_pkg::SIZE_BYTE) begin
      wbyte = req_i.wdata[7:0];
      wword = req_i.wdata[15:0];
    end
  end

  // ==========================================================================
  // next state and outputs
  // ==========================================================================
  always_comb begin
    st_next = st_reg;
    cyc_next = cyc_reg;
    last_next = last_reg;
    rd_next = rd_reg;
    ack_next = 1'b0;
    addr_next = addr_reg;
    dout_next = dout_reg;
    rstb_next = 1'b1;
    wstb_next = 1'b1;
    uwr_next = 1'b1;
    lwr_next = 1'b1;
    ube_next = 1'b1;
    lbe_next = 1'b1;
    oeu_next = oeu_reg;
    oel_next = oel_reg;
    busu_next = busu_reg;
    busl_next = busl_reg;
    unique case (st_reg)
      ebls_pkg::EBLS_IDLE: begin
        oeu_next = 1'b0;
        oel_next = 1'b0;
        busu_next = 1'b0; // free halves return to port use
        busl_next = 1'b0;
        if (req_valid_i && !ack_reg) begin
          addr_next = req_i.addr;
          cyc_next = 2'h0;
          // bus cycles per transfer
          if (!cfg_i.wide) begin
            last_next = (req_i.size == ebls_pkg::SIZE_LONG) ? 2'h3 :
                        (req_i.size == ebls_pkg::SIZE_WORD) ? 2'h1 : 2'h0;
          end else begin
            last_next = (req_i.size == ebls_pkg::SIZE_LONG) ? 2'h1 : 2'h0;
          end
          st_next = ebls_pkg::EBLS_T1;
        end
      end
      ebls_pkg::EBLS_T1: begin
        busu_next = lane.upper;
        busl_next = lane.lower;
        // undefined half driven too on byte writes in 16-bit spaces
        oeu_next = req_i.write && (lane.upper || (cfg_i.wide && lane.lower));
        oel_next = req_i.write && (lane.lower || (cfg_i.wide && lane.upper));
        dout_next = cyc_word ? wword : {wbyte, wbyte};
        if (!req_i.write) begin
          rstb_next = 1'b0; // one read strobe for both halves
        end else if (cfg_i.byte_enable_mode) begin
          wstb_next = 1'b0;
        end else if (!cfg_i.wide) begin
          uwr_next = 1'b0; // 8-bit spaces write with the upper strobe on either half
        end else begin
          uwr_next = !lane.upper;
          lwr_next = !lane.lower;
        end
        if (cfg_i.byte_enable_mode && cfg_i.wide) begin
          ube_next = !lane.upper;
          lbe_next = !lane.lower;
        end
        st_next = ebls_pkg::EBLS_T2;
      end
      ebls_pkg::EBLS_T2, ebls_pkg::EBLS_TW: begin
        rstb_next = rstb_reg;
        wstb_next = wstb_reg;
        uwr_next = uwr_reg;
        lwr_next = lwr_reg;
        ube_next = ube_reg;
        lbe_next = lbe_reg;
        if (!cfg_i.three_state) begin
          st_next = ebls_pkg::EBLS_T3; // end marks 2nd state, no waits
        end else if (st_reg == ebls_pkg::EBLS_T2 && cfg_i.waits != 2'h0) begin
          st_next = ebls_pkg::EBLS_TW;
        end else if (st_reg == ebls_pkg::EBLS_TW && !wait_zero) begin
          st_next = ebls_pkg::EBLS_TW;
        end else begin
          st_next = ebls_pkg::EBLS_T3;
        end
        if (!cfg_i.three_state || st_next == ebls_pkg::EBLS_T3) begin
          // capture only selected halves; others ignored
          if (!rstb_reg) begin
            if (lane.upper && lane.lower) begin
              rd_next = {rd_reg[15:0], data_in_i};
            end else if (lane.upper) begin
              rd_next = {rd_reg[23:0], data_in_i[15:8]};
            end else begin
              rd_next = {rd_reg[23:0], data_in_i[7:0]};
            end
          end
        end
      end
      ebls_pkg::EBLS_T3: begin
        if (cyc_reg == last_reg) begin
          ack_next = 1'b1;
          st_next = ebls_pkg::EBLS_IDLE;
        end else begin
          cyc_next = cyc_reg + 2'h1;
          addr_next = addr_reg + (cyc_word ? 24'h2 : 24'h1);
          st_next = ebls_pkg::EBLS_T1;
        end
      end
      default: st_next = ebls_pkg::EBLS_IDLE;
    endcase
    // 2-state spaces release every strobe before the third state
    if (st_reg == ebls_pkg::EBLS_T2 && !cfg_i.three_state) begin
      rstb_next = 1'b1;
      wstb_next = 1'b1;
      uwr_next = 1'b1;
      lwr_next = 1'b1;
      ube_next = 1'b1;
      lbe_next = 1'b1;
    end
  end

  // register all state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= ebls_pkg::EBLS_IDLE;
      cyc_reg <= 2'h0;
      last_reg <= 2'h0;
      rd_reg <= 32'h0;
      ack_reg <= 1'b0;
      addr_reg <= 24'h0;
      dout_reg <= 16'h0;
      rstb_reg <= 1'b1;
      wstb_reg <= 1'b1;
      uwr_reg <= 1'b1;
      lwr_reg <= 1'b1;
      ube_reg <= 1'b1;
      lbe_reg <= 1'b1;
      oeu_reg <= 1'b0;
      oel_reg <= 1'b0;
      busu_reg <= 1'b0;
      busl_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cyc_reg <= cyc_next;
      last_reg <= last_next;
      rd_reg <= rd_next;
      ack_reg <= ack_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      rstb_reg <= rstb_next;
      wstb_reg <= wstb_next;
      uwr_reg <= uwr_next;
      lwr_reg <= lwr_next;
      ube_reg <= ube_next;
      lbe_reg <= lbe_next;
      oeu_reg <= oeu_next;
      oel_reg <= oel_next;
      busu_reg <= busu_next;
      busl_reg <= busl_next;
    end
  end

  // ==========================================================================
  // outputs, all from flip-flops
  // ==========================================================================
  assign req_ack_o = ack_reg;
  assign rdata_o = rd_reg;
  assign data_out_o = dout_reg;
  assign data_oe_upper_o = oeu_reg;
  assign data_oe_lower_o = oel_reg;
  assign bus_upper_o = busu_reg;
  assign bus_lower_o = busl_reg;
  assign addr_o = addr_reg;
  assign read_strobe_n_o = rstb_reg;
  assign write_strobe_n_o = wstb_reg;
  assign upper_write_strobe_n_o = uwr_reg;
  assign lower_write_strobe_n_o = lwr_reg;
  assign upper_byte_enable_n_o = ube_reg;
  assign lower_byte_enable_n_o = lbe_reg;

  // ==========================================================================
  // checks
  // ==========================================================================
  strobe_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !read_strobe_n_o |-> upper_write_strobe_n_o && lower_write_strobe_n_o && write_strobe_n_o)
    else $error("read strobe overlaps a write strobe");
  normal_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !upper_write_strobe_n_o |-> (bus_upper_o || !cfg_i.wide) && !cfg_i.byte_enable_mode)
    else $error("upper write strobe without upper lane");
  glue_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !write_strobe_n_o |-> upper_write_strobe_n_o && lower_write_strobe_n_o)
    else $error("single write strobe mixed with lane strobes");
  byte_enable_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!upper_byte_enable_n_o || !lower_byte_enable_n_o) |->
      (upper_byte_enable_n_o == !bus_upper_o) && (lower_byte_enable_n_o == !bus_lower_o))
    else $error("byte enables disagree with lanes");
  narrow_lane_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st_reg == ebls_pkg::EBLS_T2 && !cfg_i.wide) |-> (bus_upper_o != bus_lower_o))
    else $error("8-bit space uses both or no halves");
  mux_lane_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st_reg == ebls_pkg::EBLS_T2 && !cfg_i.wide && cfg_i.mux_mode_select) |-> bus_lower_o && !bus_upper_o)
    else $error("multiplexed 8-bit space off lower half");
  two_state_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st_reg == ebls_pkg::EBLS_T1 && !cfg_i.three_state) |=> st_reg == ebls_pkg::EBLS_T2 ##1 st_reg == ebls_pkg::EBLS_T3)
    else $error("2-state space took extra states");
  wait_bound_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (st_reg == ebls_pkg::EBLS_T1) |-> ##[2:6] st_reg == ebls_pkg::EBLS_T3)
    else $error("bus cycle overran wait limit");

endmodule : ebls_top

// File: ebls_mem_model.sv
// ebls_mem_model: byte-wide external memory on the far side of the steered bus
// assumes: strobes, write data and address come from ebls_top, one clock
`timescale 1ns/100ps
module ebls_mem_model (
  input wire logic clk_i,
  input ebls_pkg::ebls_cfg_s cfg_i, // space setup
  input wire logic [23:0] addr_i, // bus address
  input wire logic [15:0] data_i, // write data pins
  input wire logic rd_n_i, // read strobe
  input wire logic wr_n_i, // single write strobe
  input wire logic uw_n_i, // upper write strobe
  input wire logic lw_n_i, // lower write strobe
  input wire logic ube_n_i, // upper byte enable
  input wire logic lbe_n_i, // lower byte enable
  output logic [15:0] data_o // read data pins
);
  // ==========================================================================
  // storage
  // ==========================================================================
  logic [7:0] mem [16]; // 16 bytes, aliased by low address bits
  logic [15:0] noise_reg = 16'ha55a; // junk on released halves
  logic [3:0] ev; // even byte of the addressed pair
  logic hi_wr; // upper lane written
  logic lo_wr; // lower lane written
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'ha0 + 8'(i);
  end
  assign ev = {addr_i[3:1], 1'b0};
  // lane qualifiers per strobe scheme
  assign hi_wr = cfg_i.byte_enable_mode ? (!wr_n_i && !ube_n_i) : !uw_n_i;
  assign lo_wr = cfg_i.byte_enable_mode ? (!wr_n_i && !lbe_n_i) : !lw_n_i;
  // ==========================================================================
  // write capture while a strobe is low
  // ==========================================================================
  always @(posedge clk_i) begin
    noise_reg <= ~noise_reg;
    if (!cfg_i.wide) begin
      // narrow device sits on one half only
      if (cfg_i.byte_enable_mode ? !wr_n_i : !uw_n_i)
        mem[addr_i[3:0]] <= cfg_i.mux_mode_select ? data_i[7:0] : data_i[15:8];
    end else begin
      if (hi_wr) mem[ev] <= data_i[15:8];
      if (lo_wr) mem[ev + 4'h1] <= data_i[7:0];
    end
  end
  // ==========================================================================
  // read drive; an undriven half shows changing junk
  // ==========================================================================
  always_comb begin
    data_o = noise_reg;
    if (!rd_n_i) begin
      if (cfg_i.wide) data_o = {mem[ev], mem[ev + 4'h1]};
      else if (cfg_i.mux_mode_select) data_o[7:0] = mem[addr_i[3:0]];
      else data_o[15:8] = mem[addr_i[3:0]];
    end
  end
endmodule : ebls_mem_model

// File: ebls_top_tb.sv
// ebls_top_tb: self-checking bench for the lane and strobe steering block
// assumes: ebls_pkg, ebls_top and ebls_mem_model compiled before it
`timescale 1ns/100ps
module ebls_top_tb;
  // ==========================================================================
  // stimulus and pins
  // ==========================================================================
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req_valid_i = 1'b0;
  ebls_pkg::ebls_req_s req_i = '0;
  ebls_pkg::ebls_cfg_s cfg_i = '0;
  logic [15:0] data_in_i;
  logic req_ack_o;
  logic [31:0] rdata_o;
  logic [15:0] data_out_o;
  logic oeu, oel, bu, bl; // lane drive and ownership
  logic [23:0] addr_o;
  logic rd_n, wr_n, uw_n, lw_n, ube_n, lbe_n; // strobes
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int runs, run_len, max_run; // bus cycles and strobe stretch
  logic [9:0] seen; // rd uw lw wr ube lbe oeu oel bu bl
  logic act;
  initial forever #2.5 clk_i = ~clk_i;
  ebls_top ebls_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .cfg_i(cfg_i), .data_in_i(data_in_i), .req_ack_o(req_ack_o),
    .rdata_o(rdata_o), .data_out_o(data_out_o), .data_oe_upper_o(oeu),
    .data_oe_lower_o(oel), .bus_upper_o(bu), .bus_lower_o(bl), .addr_o(addr_o),
    .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .upper_write_strobe_n_o(uw_n),
    .lower_write_strobe_n_o(lw_n), .upper_byte_enable_n_o(ube_n), .lower_byte_enable_n_o(lbe_n));
  ebls_mem_model ebls_mem_model_inst (.clk_i(clk_i), .cfg_i(cfg_i), .addr_i(addr_o),
    .data_i(data_out_o), .rd_n_i(rd_n), .wr_n_i(wr_n), .uw_n_i(uw_n), .lw_n_i(lw_n),
    .ube_n_i(ube_n), .lbe_n_i(lbe_n), .data_o(data_in_i));
  // ==========================================================================
  // monitor: strobe stretches and lanes seen while active
  // ==========================================================================
  assign act = !(rd_n && wr_n && uw_n && lw_n);
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      close_out;
    end else if (act) begin
      run_len++;
      if (run_len == 1) runs++;
      if (run_len > max_run) max_run = run_len;
      seen = seen | {~rd_n, ~uw_n, ~lw_n, ~wr_n, ~ube_n, ~lbe_n, oeu, oel, bu, bl};
    end else begin
      run_len = 0;
    end
  end
  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // space setup, changed only while idle
  task automatic set_cfg(input logic w, input logic t, input logic [1:0] wt, input logic m, input logic b);
    @(negedge clk_i);
    cfg_i = '{wide: w, three_state: t, waits: wt, mux_mode_select: m, byte_enable_mode: b};
  endtask : set_cfg
  // one transfer: hold request to ack, then judge lanes, timing and data
  task automatic acc(input logic [23:0] a, input logic [1:0] sz, input logic wr, input logic [31:0] wd,
    input logic [9:0] xs, input int xr, input int xm);
    int n;
    logic [31:0] m;
    m = (sz == 2'h0) ? 32'hff : (sz == 2'h1) ? 32'hffff : 32'hffffffff;
    @(negedge clk_i);
    runs = 0;
    max_run = 0;
    seen = '0;
    req_i = '{addr: a, size: sz, write: wr, wdata: wd};
    req_valid_i = 1'b1;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (req_ack_o !== 1'b1 && n < 200);
    chk(req_ack_o, 1'b1);
    chk(32'(seen), 32'(xs));
    chk(runs, xr);
    chk(max_run, xm);
    if (!wr) chk(rdata_o & m, wd);
    // request stands through the edge that samples ack, then drops
    @(negedge clk_i);
    req_valid_i = 1'b0;
  endtask : acc
  // ==========================================================================
  // scenarios
  // ==========================================================================
  // narrow normal space, 2-state despite three waits programmed
  task automatic s_narrow;
    set_cfg(1'b0, 1'b0, 2'h3, 1'b0, 1'b0);
    acc(24'h8, 2'h2, 1'b0, 32'ha8a9aaab, 10'h202, 4, 1);
    // byte-enable scheme on a narrow 3-state space with one wait
    set_cfg(1'b0, 1'b1, 2'h1, 1'b0, 1'b1);
    acc(24'h2, 2'h0, 1'b1, 32'h77, 10'h04a, 1, 3);
    acc(24'h2, 2'h0, 1'b0, 32'h77, 10'h202, 1, 3);
  endtask : s_narrow
  // narrow multiplexed space, 3-state with two waits
  task automatic s_mux;
    set_cfg(1'b0, 1'b1, 2'h2, 1'b1, 1'b0);
    acc(24'hc, 2'h1, 1'b1, 32'h5aa5, 10'h105, 2, 4);
    acc(24'hc, 2'h1, 1'b0, 32'h5aa5, 10'h201, 2, 4);
  endtask : s_mux
  // wide byte reads, both modes, both parities
  task automatic s_wide_rd;
    for (int m = 0; m < 2; m++) begin
      set_cfg(1'b1, 1'b0, 2'h0, m[0], 1'b0);
      acc(24'h6, 2'h0, 1'b0, 32'ha6, 10'h202, 1, 1);
      acc(24'h7, 2'h0, 1'b0, 32'ha7, 10'h201, 1, 1);
    end
  endtask : s_wide_rd
  // wide writes with per-half strobes, then read back
  task automatic s_wide_wr;
    set_cfg(1'b1, 1'b0, 2'h1, 1'b0, 1'b0);
    acc(24'h3, 2'h0, 1'b1, 32'h3c, 10'h08d, 1, 1);
    acc(24'h0, 2'h1, 1'b1, 32'h1234, 10'h18f, 1, 1);
    acc(24'h8, 2'h2, 1'b1, 32'hdeadbeef, 10'h18f, 2, 1);
    acc(24'h3, 2'h0, 1'b0, 32'h3c, 10'h201, 1, 1);
    acc(24'h0, 2'h1, 1'b0, 32'h1234, 10'h203, 1, 1);
    acc(24'h8, 2'h2, 1'b0, 32'hdeadbeef, 10'h203, 2, 1);
  endtask : s_wide_wr
  // byte-enable scheme on a wide 3-state space
  task automatic s_byte_en;
    set_cfg(1'b1, 1'b1, 2'h0, 1'b0, 1'b1);
    acc(24'h4, 2'h0, 1'b0, 32'ha4, 10'h222, 1, 2);
    acc(24'h5, 2'h0, 1'b1, 32'h55, 10'h05d, 1, 2);
    acc(24'h6, 2'h1, 1'b0, 32'ha6a7, 10'h233, 1, 2);
    acc(24'h5, 2'h0, 1'b0, 32'h55, 10'h211, 1, 2);
  endtask : s_byte_en
  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    resetn_i = 1'b1;
    chk({rd_n, wr_n, uw_n, lw_n, ube_n, lbe_n}, 6'h3f);
    s_narrow;
    s_mux;
    s_wide_rd;
    s_wide_wr;
    s_byte_en;
    close_out;
  end
endmodule : ebls_top_tb
